/* address_subreg_file.sv */
// Address register: eight word-wide sub-registers in flip-flops.
// Assumes one write port from software and two combinational reads.
`timescale 1ns/1ps
`include "opdec_consts.svh"

module address_subreg_file (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rstn,
   // Write port
   input  wire logic                      wrEn,
   input  wire logic [`OPD_SEL_W-1:0]     wrSel,
   input  wire logic [`OPD_WORD_W-1:0]    wrData,
   // Read ports
   input  wire logic [`OPD_SEL_W-1:0]     rdSelA,
   output      logic [`OPD_WORD_W-1:0]    rdDataA,
   input  wire logic [`OPD_SEL_W-1:0]     rdSelB,
   output      logic [`OPD_WORD_W-1:0]    rdDataB
);

   logic [`OPD_WORD_W-1:0] subReg [`OPD_SUBREGS];

   genvar g;
   generate
      for (g = 0; g < `OPD_SUBREGS; g = g + 1) begin : gSub
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               subReg[g] <= `OPD_WORD_ZERO;
            end else if (wrEn && wrSel == `OPD_SEL_W'(g)) begin
               subReg[g] <= wrData;
            end
         end
      end
   endgenerate

   // Each selector value picks one of the eight words.
   assign rdDataA = subReg[rdSelA];
   assign rdDataB = subReg[rdSelB];

endmodule

/* opdec_consts.svh */
// Constants for the operand register address decoder.
// Assumes inclusion by the package and the design modules only.
`ifndef OPDEC_CONSTS_SVH
`define OPDEC_CONSTS_SVH

// ****************************************************************
// Field widths
// ****************************************************************
`define OPD_INDEX_W      8
`define OPD_OFFSET_W     5
`define OPD_SEL_W        3
`define OPD_ADDR_W       13
`define OPD_WORD_W       16
`define OPD_ARCH_TYPE_W  4
`define OPD_ARCH_NUM_W   4
`define OPD_SUBREGS      8
`define OPD_REGADDR_W    4

// ****************************************************************
// Register file select codes
// ****************************************************************
`define OPD_FILE_ARCH    2'h0
`define OPD_FILE_GEN     2'h1
`define OPD_FILE_MSG     2'h2
`define OPD_FILE_RSVD    2'h3

// ****************************************************************
// Valid register index ranges
// ****************************************************************
`define OPD_GEN_LAST     8'h7F
`define OPD_MSG_LAST     8'h0F

// ****************************************************************
// Register map
// ****************************************************************
`define OPD_REG_SUB_LAST 4'h7
`define OPD_REG_CTRL     4'h8
`define OPD_REG_STATUS   4'h9
`define OPD_REG_LASTADDR 4'hA
`define OPD_REG_CNT_DIR  4'hB
`define OPD_REG_CNT_IND  4'hC
`define OPD_REG_CNT_IMM  4'hD
`define OPD_REG_CNT_INV  4'hE

// ****************************************************************
// Control and status bits, reset values
// ****************************************************************
`define OPD_CTRL_EN      0
`define OPD_CTRL_DROP    1
`define OPD_CTRL_RESET   2'h1
`define OPD_STAT_INV     0
`define OPD_STAT_RSVD    1
`define OPD_WORD_ZERO    16'h0000
`define OPD_ADDR_ZERO    13'h0000
`define OPD_CNT_ONE      16'h0001

`endif

/* opdec_pkg.sv */
// Types shared by the operand register address decoder.
// Assumes the constants header is on the include path.
`include "opdec_consts.svh"

package opdec_pkg;

   typedef enum logic [1:0] {
      FILE_ARCH = `OPD_FILE_ARCH,
      FILE_GEN  = `OPD_FILE_GEN,
      FILE_MSG  = `OPD_FILE_MSG,
      FILE_RSVD = `OPD_FILE_RSVD
   } register_file_select_t;

   typedef struct packed {
      register_file_select_t                   registerFileSelect;
      logic                       operandAddressingSelect;
      logic                       immediate;
      logic [`OPD_INDEX_W-1:0]    operandRegisterIndex;
      logic [`OPD_OFFSET_W-1:0]   operandByteOffset;
      logic [`OPD_SEL_W-1:0]      addressSubregSelect;
   } operand_req_t;

   typedef struct packed {
      logic [`OPD_ADDR_W-1:0]      byteAddr;
      logic                        invalid;
      logic                        indirect;
      logic                        immediate;
      logic                        isArch;
      logic [`OPD_ARCH_TYPE_W-1:0] archType;
      logic [`OPD_ARCH_NUM_W-1:0]  archNum;
      logic [`OPD_OFFSET_W-1:0]    archSub;
   } operand_res_t;

endpackage

/* operand_datapath_model.sv */
// Operand datapath stand-in: takes each decoded result as it is offered.
// Assumes results stand for one cycle with resValid, as the decoder gives.
`timescale 1ns/1ps

module operand_datapath_model (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rstn,
   // Decoded result
   input  wire logic                     resValid,
   input  wire opdec_pkg::operand_res_t  res,
   // Observation
   output      logic [15:0]              nTaken,
   output      opdec_pkg::operand_res_t  lastRes
);
   // The datapath never stalls, so every cycle with resValid high is one operand taken.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         nTaken  <= 16'h0000;
         lastRes <= '0;
      end else if (resValid) begin
         nTaken  <= nTaken + 16'h0001;
         lastRes <= res;
      end
   end
endmodule

/* operand_register_address_decode.sv */
// Operand register address decoder with its software register port.
// Assumes requests from the fetch stage and a datapath that takes the
// registered result one cycle after each request.
`timescale 1ns/1ps
`include "opdec_consts.svh"

module operand_register_address_decode (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         rstn,
   // Operand request from fetch
   input  wire logic                         reqValid,
   input  wire opdec_pkg::operand_req_t      req,
   // Decoded result to the operand datapath
   output      logic                         resValid,
   output      opdec_pkg::operand_res_t      res,
   // Software register port
   input  wire logic [`OPD_REGADDR_W-1:0]    regAddr,
   input  wire logic [`OPD_WORD_W-1:0]       regWdata,
   input  wire logic                         regWrite,
   input  wire logic                         regRead,
   output      logic [`OPD_REGADDR_W-1:0]    unusedAddrEcho,
   output      logic [`OPD_WORD_W-1:0]       regRdata
);

   // ****************************************************************
   // Decode helpers
   // ****************************************************************

   // True when the index lies outside the populated range of its file.
   function automatic logic indexReserved(
      input opdec_pkg::register_file_select_t         sel,
      input logic [`OPD_INDEX_W-1:0]     idx
   );
      logic r;
      r = 1'b0;
      case (sel)
         opdec_pkg::FILE_GEN: begin
            r = (idx > `OPD_GEN_LAST);
         end
         opdec_pkg::FILE_MSG: begin
            r = (idx > `OPD_MSG_LAST);
         end
         opdec_pkg::FILE_ARCH: begin
            r = 1'b0;
         end
         default: begin
            r = 1'b1;
         end
      endcase
      return r;
   endfunction

   // True when the address falls on a sub-register word.
   function automatic logic isSubAddr(
      input logic [`OPD_REGADDR_W-1:0] a
   );
      return (a <= `OPD_REG_SUB_LAST);
   endfunction

   // ****************************************************************
   // Control register
   // ****************************************************************

   logic [1:0] ctrl;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= `OPD_CTRL_RESET;
      end else if (regWrite && regAddr == `OPD_REG_CTRL) begin
         ctrl <= regWdata[1:0];
      end
   end

   // Dropping keeps reserved operands away from the datapath at the cost
   // of a silent slot; the sticky flag and the counter still record them.
   logic decodeEn;
   logic dropInvalid;

   assign decodeEn    = ctrl[`OPD_CTRL_EN];
   assign dropInvalid = ctrl[`OPD_CTRL_DROP];

   // ****************************************************************
   // Address sub-registers
   // ****************************************************************

   // Software and the decoder read the sub-registers through separate
   // ports, so a bus read never disturbs an operand decode.
   logic [`OPD_WORD_W-1:0] subWordDecode;
   logic [`OPD_WORD_W-1:0] subWordBus;

   address_subreg_file subregs (
      .clk     (clk),
      .rstn    (rstn),
      .wrEn    (regWrite && isSubAddr(regAddr)),
      .wrSel   (regAddr[`OPD_SEL_W-1:0]),
      .wrData  (regWdata),
      .rdSelA  (req.addressSubregSelect),
      .rdDataA (subWordDecode),
      .rdSelB  (regAddr[`OPD_SEL_W-1:0]),
      .rdDataB (subWordBus)
   );

   // ****************************************************************
   // Operand decode
   // ****************************************************************

   // The result is formed in one combinational step so that the datapath
   // sees it exactly one cycle after the request, with no stall path.
   opdec_pkg::operand_res_t next_res;
   logic                    next_resValid;

   always_comb begin
      next_res           = '0;
      next_resValid      = reqValid && decodeEn;
      next_res.immediate = req.immediate;
      next_res.indirect  = req.operandAddressingSelect;
      if (req.immediate) begin
         // Location fields carry immediate data here, so none is read.
         next_res.byteAddr = `OPD_ADDR_ZERO;
      end else if (req.operandAddressingSelect) begin
         // The word may hold more than 13 bits; upper bits are beyond
         // the register space and are dropped.
         next_res.byteAddr =
            subWordDecode[`OPD_ADDR_W-1:0];
      end else begin
         next_res.byteAddr = {req.operandRegisterIndex,
                              req.operandByteOffset};
         if (req.registerFileSelect == opdec_pkg::FILE_ARCH) begin
            next_res.isArch   = 1'b1;
            next_res.archType = req.operandRegisterIndex[
               `OPD_INDEX_W-1:`OPD_ARCH_NUM_W];
            next_res.archNum  = req.operandRegisterIndex[
               `OPD_ARCH_NUM_W-1:0];
            next_res.archSub  = req.operandByteOffset;
         end else if (indexReserved(req.registerFileSelect,
                                    req.operandRegisterIndex)) begin
            // No address leaves with a reserved index.
            next_res.invalid  = 1'b1;
            next_res.byteAddr = `OPD_ADDR_ZERO;
            if (dropInvalid) begin
               next_resValid = 1'b0;
            end
         end
         // Low five bits are a byte within one 256-bit register.
      end
   end

   logic decodedInvalid;

   assign decodedInvalid = reqValid && decodeEn && next_res.invalid;

   // ****************************************************************
   // Result registers
   // ****************************************************************

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         resValid <= 1'b0;
      end else begin
         resValid <= next_resValid;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         res <= '0;
      end else if (reqValid && decodeEn) begin
         res <= next_res;
      end
   end

   // ****************************************************************
   // Status: sticky invalid flag and last address
   // ****************************************************************

   logic stickyInvalid;
   logic stickyReservedFile;
   logic clearStatus;

   assign clearStatus = regWrite && regAddr == `OPD_REG_STATUS;

   // A new event in the clearing cycle wins, so it is never lost.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stickyInvalid <= 1'b0;
      end else if (decodedInvalid) begin
         stickyInvalid <= 1'b1;
      end else if (clearStatus && regWdata[`OPD_STAT_INV]) begin
         stickyInvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stickyReservedFile <= 1'b0;
      end else if (decodedInvalid &&
                   req.registerFileSelect == opdec_pkg::FILE_RSVD) begin
         stickyReservedFile <= 1'b1;
      end else if (clearStatus && regWdata[`OPD_STAT_RSVD]) begin
         stickyReservedFile <= 1'b0;
      end
   end

   logic [`OPD_ADDR_W-1:0] lastAddr;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lastAddr <= `OPD_ADDR_ZERO;
      end else if (next_resValid && !next_res.immediate) begin
         lastAddr <= next_res.byteAddr;
      end
   end

   // ****************************************************************
   // Decode counters
   // ****************************************************************

   // Counters wrap; software samples them often enough to see wraps.
   logic [`OPD_WORD_W-1:0] cntDirect;
   logic [`OPD_WORD_W-1:0] cntIndirect;
   logic [`OPD_WORD_W-1:0] cntImmediate;
   logic [`OPD_WORD_W-1:0] cntInvalid;
   logic                   seen;

   assign seen = reqValid && decodeEn;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cntDirect <= `OPD_WORD_ZERO;
      end else if (seen && !req.immediate &&
                   !req.operandAddressingSelect) begin
         cntDirect <= cntDirect + `OPD_CNT_ONE;
      end else if (regWrite && regAddr == `OPD_REG_CNT_DIR) begin
         cntDirect <= `OPD_WORD_ZERO;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cntIndirect <= `OPD_WORD_ZERO;
      end else if (seen && !req.immediate &&
                   req.operandAddressingSelect) begin
         cntIndirect <= cntIndirect + `OPD_CNT_ONE;
      end else if (regWrite && regAddr == `OPD_REG_CNT_IND) begin
         cntIndirect <= `OPD_WORD_ZERO;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cntImmediate <= `OPD_WORD_ZERO;
      end else if (seen && req.immediate) begin
         cntImmediate <= cntImmediate + `OPD_CNT_ONE;
      end else if (regWrite && regAddr == `OPD_REG_CNT_IMM) begin
         cntImmediate <= `OPD_WORD_ZERO;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cntInvalid <= `OPD_WORD_ZERO;
      end else if (decodedInvalid) begin
         cntInvalid <= cntInvalid + `OPD_CNT_ONE;
      end else if (regWrite && regAddr == `OPD_REG_CNT_INV) begin
         cntInvalid <= `OPD_WORD_ZERO;
      end
   end

   // ****************************************************************
   // Register read port
   // ****************************************************************

   logic [`OPD_WORD_W-1:0] next_regRdata;

   always_comb begin
      next_regRdata = `OPD_WORD_ZERO;
      if (isSubAddr(regAddr)) begin
         next_regRdata = subWordBus;
      end else begin
         case (regAddr)
            `OPD_REG_CTRL: begin
               next_regRdata[1:0] = ctrl;
            end
            `OPD_REG_STATUS: begin
               next_regRdata[`OPD_STAT_INV]  = stickyInvalid;
               next_regRdata[`OPD_STAT_RSVD] = stickyReservedFile;
            end
            `OPD_REG_LASTADDR: begin
               next_regRdata[`OPD_ADDR_W-1:0] = lastAddr;
            end
            `OPD_REG_CNT_DIR: begin
               next_regRdata = cntDirect;
            end
            `OPD_REG_CNT_IND: begin
               next_regRdata = cntIndirect;
            end
            `OPD_REG_CNT_IMM: begin
               next_regRdata = cntImmediate;
            end
            `OPD_REG_CNT_INV: begin
               next_regRdata = cntInvalid;
            end
            default: begin
               next_regRdata = `OPD_WORD_ZERO;
            end
         endcase
      end
   end

   // Read data stand for exactly the cycle after the strobe.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         regRdata <= `OPD_WORD_ZERO;
      end else if (regRead) begin
         regRdata <= next_regRdata;
      end else begin
         regRdata <= `OPD_WORD_ZERO;
      end
   end

   // Address of the last read, kept for bus debug.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         unusedAddrEcho <= '0;
      end else if (regRead) begin
         unusedAddrEcho <= regAddr;
      end
   end

endmodule

/* operand_register_address_decode_sva.sv */
// Checker for the operand decoder, watching the top module's ports only.
// Assumes a single clock domain and the one-cycle result latency.
`timescale 1ns/1ps

module operand_register_address_decode_sva (
   // Clock and reset
   input wire logic                     clk,
   input wire logic                     rstn,
   // Decode port
   input wire logic                     reqValid,
   input wire opdec_pkg::operand_req_t  req,
   input wire logic                     resValid,
   input wire opdec_pkg::operand_res_t  res,
   // Register port
   input wire logic [3:0]               regAddr,
   input wire logic [15:0]              regWdata,
   input wire logic                     regWrite,
   input wire logic                     regRead,
   input wire logic [3:0]               unusedAddrEcho,
   input wire logic [15:0]              regRdata
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   logic direct;
   assign direct = reqValid && !req.immediate && !req.operandAddressingSelect;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // A disabled decoder leaves res alone, so each check waits for resValid.
   a_index_high_bits: assert property (direct
      |=> resValid && !res.invalid
      -> res.byteAddr[12:5] == $past(req.operandRegisterIndex))
      else $error("index not in address bits 12 to 5");
   a_offset_low_bits: assert property (direct
      |=> resValid && !res.invalid
      -> res.byteAddr[4:0] == $past(req.operandByteOffset))
      else $error("offset not in address bits 4 to 0");
   a_gen_range: assert property (direct
      && req.registerFileSelect == opdec_pkg::FILE_GEN |=> resValid
      -> res.invalid == $past(req.operandRegisterIndex[7]))
      else $error("general file range decoded wrongly");
   a_msg_range: assert property (direct
      && req.registerFileSelect == opdec_pkg::FILE_MSG |=> resValid
      -> res.invalid == ($past(req.operandRegisterIndex) > 8'h0F))
      else $error("message file range decoded wrongly");
   a_arch_fields: assert property (direct
      && req.registerFileSelect == opdec_pkg::FILE_ARCH |=> resValid
      -> res.isArch && !res.invalid
      && {res.archType, res.archNum} == $past(req.operandRegisterIndex)
      && res.archSub == $past(req.operandByteOffset))
      else $error("architecture fields decoded wrongly");
   a_indirect_valid: assert property (reqValid
      && !req.immediate && req.operandAddressingSelect |=> resValid
      -> res.indirect && !res.invalid)
      else $error("indirect operand flagged invalid");
   a_imm_no_addr: assert property (reqValid && req.immediate
      |=> resValid
      -> res.immediate && !res.invalid && res.byteAddr == 13'h0000)
      else $error("immediate operand formed an address");
   a_mode_bit: assert property (reqValid && !req.immediate
      |=> resValid -> res.indirect == $past(req.operandAddressingSelect))
      else $error("addressing bit not followed");

   c_direct: cover property (direct ##1 resValid);
   c_indirect: cover property (reqValid && req.operandAddressingSelect
      ##1 resValid);
   c_invalid: cover property (resValid && res.invalid);
endmodule

/* operand_register_address_decode_tb_top.sv */
// Self-checking bench for the operand decoder and its register port.
// Assumes the package is compiled first and a 100 MHz clock.
`timescale 1ns/1ps

module operand_register_address_decode_tb_top;
   logic                     clk;
   logic                     rstn;
   logic                     reqValid;
   opdec_pkg::operand_req_t  req;
   logic                     resValid;
   opdec_pkg::operand_res_t  res;
   logic [3:0]               regAddr;
   logic [15:0]              regWdata;
   logic                     regWrite;
   logic                     regRead;
   logic [15:0]              regRdata;
   logic [3:0]               echo;
   logic [15:0]              nTaken;
   opdec_pkg::operand_res_t  lastRes;
   int                       errors;
   int                       n_compared;
   logic [15:0]              word;
   logic [15:0]              n0;

   operand_register_address_decode uut (
      .clk(clk), .rstn(rstn), .reqValid(reqValid), .req(req),
      .resValid(resValid), .res(res), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .unusedAddrEcho(echo), .regRdata(regRdata));

   operand_datapath_model dp (
      .clk(clk), .rstn(rstn), .resValid(resValid), .res(res),
      .nTaken(nTaken), .lastRes(lastRes));

   always #5 clk = ~clk;

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic finish_test();
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      chk("regRdata", e, regRdata);
   endtask

   // One request, then a look at resValid once the result edge has landed.
   task automatic dec(input logic [1:0] f, input logic ind, imm,
                      input logic [7:0] idx, input logic [4:0] off,
                      input logic [2:0] sel, input logic expV);
      @(posedge clk);
      reqValid <= 1'b1;
      req <= '{opdec_pkg::register_file_select_t'(f), ind, imm, idx, off, sel};
      @(posedge clk);
      reqValid <= 1'b0;
      #1;
      chk("resValid", {15'h0000, expV}, {15'h0000, resValid});
   endtask

   function automatic logic [15:0] ad();
      return {3'h0, res.byteAddr};
   endfunction

   function automatic logic [15:0] inv();
      return {15'h0000, res.invalid};
   endfunction

   initial begin
      #200000;
      errors++;
      finish_test();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      reqValid = 1'b0;
      req = '0;
      regAddr = 4'h0;
      regWdata = 16'h0000;
      regWrite = 1'b0;
      regRead = 1'b0;
      errors = 0;
      n_compared = 0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rd(4'h8, 16'h0001);
      rd(4'h9, 16'h0000);
      wr(4'hF, 16'hFFFF);
      rd(4'hF, 16'h0000);
      dec(2'h1, 1'b0, 1'b0, 8'h05, 5'h03, 3'h0, 1'b1);
      chk("byteAddr", 16'h00A3, ad());
      dec(2'h1, 1'b0, 1'b0, 8'h7F, 5'h1F, 3'h0, 1'b1);
      chk("byteAddr", 16'h0FFF, ad());
      chk("invalid", 16'h0000, inv());
      dec(2'h1, 1'b0, 1'b0, 8'h80, 5'h00, 3'h0, 1'b1);
      chk("invalid", 16'h0001, inv());
      chk("byteAddr", 16'h0000, ad());
      dec(2'h2, 1'b0, 1'b0, 8'h0F, 5'h1F, 3'h0, 1'b1);
      chk("byteAddr", 16'h01FF, ad());
      chk("invalid", 16'h0000, inv());
      dec(2'h2, 1'b0, 1'b0, 8'h10, 5'h00, 3'h0, 1'b1);
      chk("invalid", 16'h0001, inv());
      dec(2'h3, 1'b0, 1'b0, 8'h01, 5'h00, 3'h0, 1'b1);
      chk("invalid", 16'h0001, inv());
      dec(2'h0, 1'b0, 1'b0, 8'hA5, 5'h11, 3'h0, 1'b1);
      chk("arch", 16'h1A50, {3'h0, res.isArch, res.archType,
          res.archNum, 3'h0, res.invalid});
      chk("archSub", 16'h0011, {11'h000, res.archSub});
      rd(4'h9, 16'h0003);
      wr(4'h9, 16'h0003);
      rd(4'h9, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         word = 16'hE000 | 16'(i * 16'h0123 + 16'h0001);
         wr(4'(i), word);
         rd(4'(i), word);
         dec(2'h1, 1'b1, 1'b0, 8'hFF, 5'h1F, 3'(i), 1'b1);
         chk("byteAddr", {3'h0, word[12:0]}, ad());
         chk("invalid", 16'h0000, inv());
         chk("indirect", 16'h0001, {15'h0000, res.indirect});
      end
      dec(2'h1, 1'b1, 1'b1, 8'hFF, 5'h1F, 3'h7, 1'b1);
      chk("byteAddr", 16'h0000, ad());
      chk("immInv", 16'h0002, {14'h0000, res.immediate, res.invalid});
      dec(2'h2, 1'b0, 1'b1, 8'h40, 5'h05, 3'h0, 1'b1);
      chk("byteAddr", 16'h0000, ad());
      // Two requests on consecutive edges must both reach the datapath.
      // The previous result is counted one edge later; let it land first.
      @(posedge clk);
      #1;
      n0 = nTaken;
      @(posedge clk);
      reqValid <= 1'b1;
      req <= '{opdec_pkg::FILE_GEN, 1'b0, 1'b0, 8'h01, 5'h00, 3'h0};
      @(posedge clk);
      req <= '{opdec_pkg::FILE_GEN, 1'b0, 1'b0, 8'h02, 5'h01, 3'h0};
      @(posedge clk);
      reqValid <= 1'b0;
      @(posedge clk);
      #1;
      chk("nTaken", n0 + 16'h0002, nTaken);
      chk("lastAddr", 16'h0041, {3'h0, lastRes.byteAddr});
      wr(4'h8, 16'h0000);
      dec(2'h1, 1'b0, 1'b0, 8'h03, 5'h00, 3'h0, 1'b0);
      chk("byteAddr", 16'h0041, ad());
      wr(4'h8, 16'h0003);
      dec(2'h1, 1'b0, 1'b0, 8'h90, 5'h00, 3'h0, 1'b0);
      chk("invalid", 16'h0001, inv());
      rd(4'hE, 16'h0004);
      rd(4'hA, 16'h0041);
      rd(4'hB, 16'h000A);
      rd(4'hC, 16'h0008);
      rd(4'hD, 16'h0002);
      chk("echo", 16'h000D, {12'h000, echo});
      finish_test();
   end
endmodule

bind operand_register_address_decode operand_register_address_decode_sva chk_i (
   .clk(clk), .rstn(rstn), .reqValid(reqValid), .req(req),
   .resValid(resValid), .res(res), .regAddr(regAddr),
   .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
   .unusedAddrEcho(unusedAddrEcho), .regRdata(regRdata));
